/* udc_pkg.sv */
// package of register map, field positions and carrier types for the device control block
package udc_pkg;

  // ---------------------------------------------------------------
  // register byte addresses
  // ---------------------------------------------------------------
  localparam logic [11:0] ADDR_CFG     = 12'h800; // device configuration
  localparam logic [11:0] ADDR_CTL     = 12'h804; // device control
  localparam logic [11:0] ADDR_STAT    = 12'h808; // device status
  localparam logic [11:0] ADDR_INMSK   = 12'h810; // common IN endpoint mask
  localparam logic [11:0] ADDR_OUTMSK  = 12'h814; // common OUT endpoint mask
  localparam logic [11:0] ADDR_ALLEP   = 12'h818; // all endpoints interrupt bits

  // ---------------------------------------------------------------
  // configuration fields
  // ---------------------------------------------------------------
  localparam int CFG_SPD_LO  = 0;  // speed select low bit
  localparam int CFG_NZLS    = 2;  // status OUT non-zero reject
  localparam logic [1:0] SPD_HIGH = 2'h0; // high speed
  localparam logic [1:0] SPD_FULL = 2'h1; // full speed

  // ---------------------------------------------------------------
  // control fields
  // ---------------------------------------------------------------
  localparam int CTL_RWK   = 0;  // remote resume request
  localparam int CTL_SD    = 1;  // soft link drop
  localparam int CTL_GLOBAL_IN_NAK_STATE  = 2;  // global IN nak state
  localparam int CTL_GLOBAL_OUT_NAK_STATE  = 3;  // global OUT nak state
  localparam int CTL_TST   = 4;  // test pattern select low bit
  localparam int CTL_SGIN  = 7;  // set global IN nak
  localparam int CTL_CGIN  = 8;  // clear global IN nak
  localparam int CTL_SGON  = 9;  // set global OUT nak
  localparam int CTL_CGON  = 10; // clear global OUT nak
  localparam int CTL_INIT  = 11; // init done notify

  // ---------------------------------------------------------------
  // status fields and masks
  // ---------------------------------------------------------------
  localparam int STAT_SUSPEND_STATE = 0;  // suspend state
  localparam int STAT_ES   = 1;  // enumerated speed low bit
  localparam int STAT_FN   = 8;  // frame number low bit
  localparam logic [31:0] IN_MSK_BITS  = 32'h0000205B; // bits 13,6,4,3,1,0
  localparam logic [31:0] OUT_MSK_BITS = 32'h0000405A; // bits 14,6,4,3,1
  localparam int ALL_OUT_LO = 16; // OUT endpoint bits start
  localparam int NAK_DELAY  = 4;  // cycles until nak effective flag rises
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    TST_OFF  = 3'h0, TST_J = 3'h1, TST_K = 3'h2,
    TST_SE0  = 3'h3, TST_PKT = 3'h4, TST_FORCE = 3'h5
  } udc_test_t;

  typedef enum logic [1:0] {
    HS_NAK = 2'h0, HS_ACK = 2'h1, HS_STALL = 2'h2
  } udc_hs_t;

  // one packet/token event from the link engine
  typedef struct packed {
    logic       out_valid;   // OUT data packet arrived
    logic       status_stage;// packet is in status OUT stage
    logic       nonzero;     // packet length not zero
    logic       in_valid;    // IN token arrived
    logic       ep_nak;      // endpoint nak setting
    logic       ep_stall;    // endpoint stall setting
    logic       fifo_ok;     // fifo has room / data
  } udc_txn_t;

  // answer to the link engine
  typedef struct packed {
    udc_hs_t    out_hs;      // handshake for OUT
    logic       out_save;    // keep OUT data
    udc_hs_t    in_hs;       // handshake for IN
  } udc_resp_t;

endpackage : udc_pkg

/* udc_ctrl.sv */
// device control and status block with AXI4-Lite register slave
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
// How it works
// (RL1) status-OUT bit 0: normal packet handling
// (RL2) status-OUT bit 1: STALL, discard data
// (RL3) speed select 00 high, 01 full
// (RL4) software sets init-done bit after power-off
// (RL5) clear-OUT-NAK write clears OUT NAK state
// (RL6) set-OUT-NAK write sets state, raises flag
// (RL7) software clears effective flags before re-setting
// (RL8) clear-IN-NAK write clears IN NAK state
// (RL9) set-IN-NAK write sets state, raises flag
// (RL10) nonzero test code drives test pattern
// (RL11) software sets high-speed current feature too
// (RL12) OUT NAK state forces NAK, no save
// (RL13) IN NAK state forces NAK on IN
// (RL14) disconnect: drop to full, then pull-up off
// (RL15) remote wakeup in suspend drives resume
// (RL16) status holds last SOF frame number
// (RL17) enumerated speed reported, 00 high 01 full
// (RL18) suspend bit reads 0 while suspended
// (RL19) IN mask gates per-endpoint IN flags
// (RL20) OUT mask gates per-endpoint OUT flags
// (RL21) endpoint interrupts in all-endpoints register
// (RL22) command bits pulse, read zero; reserved zero
module udc_ctrl #(
  parameter int N_EP = 6 // endpoints per direction
) (
  input  wire logic                aclk,
  input  wire logic                aresetn,
  // AXI4-Lite slave
  input  wire logic [11:0]         s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [11:0]         s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  // link engine side (same clock)
  input  wire udc_pkg::udc_txn_t   txn,
  output udc_pkg::udc_resp_t       resp,
  input  wire logic                sof_valid,
  input  wire logic [13:0]         sof_frame,
  input  wire logic                enum_done,
  input  wire logic [1:0]          enum_speed,
  input  wire logic                suspended,
  input  wire logic [N_EP*32-1:0]  in_ep_flags,
  input  wire logic [N_EP*32-1:0]  out_ep_flags,
  output logic                     speed_select_hs,
  output logic [2:0]               test_pattern_select,
  output logic                     test_mode_active,
  output logic                     hs_fallback,
  output logic                     dp_pullup_en,
  output logic                     remote_resume_drive,
  output logic                     init_done_notify,
  output logic                     global_in_nak_effective_flag,
  output logic                     global_out_nak_effective_flag,
  input  wire logic                clear_in_nak_flag,
  input  wire logic                clear_out_nak_flag
);
  import udc_pkg::*;

  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  logic [1:0]  speed_select_q;           // connection speed
  logic        status_out_nonzero_reject_q; // status OUT rejection
  logic        remote_resume_request_q;  // wakeup request
  logic        soft_link_drop_q;         // disconnect request
  logic [2:0]  test_q;                   // test pattern code
  logic        init_q;                   // init done bit
  logic        global_in_nak_state_q;    // IN nak state
  logic        global_out_nak_state_q;   // OUT nak state
  logic [31:0] in_msk_q;                 // common IN mask
  logic [31:0] out_msk_q;                // common OUT mask
  logic [13:0] sof_frame_number_q;       // last SOF frame
  logic [1:0]  enum_speed_q;             // captured speed
  logic [N_EP-1:0] in_int_q;             // per IN endpoint interrupt
  logic [N_EP-1:0] out_int_q;            // per OUT endpoint interrupt

  // ---------------------------------------------------------------
  // write channel: address and data taken in either order
  // ---------------------------------------------------------------
  logic        aw_got_q;   // address captured
  logic        w_got_q;    // data captured
  logic [11:0] aw_q;       // held address
  logic [31:0] wd_q;       // held data
  logic        wr_fire;    // both halves present this cycle
  logic        wr_ctl;     // write hits control register

  assign s_axi_awready = !aw_got_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_got_q && !s_axi_bvalid;
  assign wr_fire       = aw_got_q && w_got_q;
  // byte lane 0 and 1 both matter for control; strobes are not checked, unstrobed lanes write as zero
  assign wr_ctl        = wr_fire && (aw_q == ADDR_CTL);

  // capture address and data, release on response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q <= 1'b0;
      w_got_q  <= 1'b0;
      aw_q     <= 12'h000;
      wd_q     <= 32'h00000000;
    end else if (wr_fire) begin
      aw_got_q <= 1'b0;
      w_got_q  <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_q <= 1'b1;
        aw_q     <= {s_axi_awaddr[11:2], 2'h0};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_q <= 1'b1;
        // byte strobes merge into zero; registers are written as whole words
        for (int i = 0; i < 4; i++) begin
          wd_q[i*8 +: 8] <= s_axi_wstrb[i] ? s_axi_wdata[i*8 +: 8] : 8'h00;
        end
      end
    end
  end

  // write response, slave error for unmapped address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (aw_q == ADDR_CFG || aw_q == ADDR_CTL || aw_q == ADDR_INMSK ||
                       aw_q == ADDR_OUTMSK || aw_q == ADDR_STAT || aw_q == ADDR_ALLEP)
                      ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // configuration and mask registers
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      speed_select_q              <= SPD_HIGH;
      status_out_nonzero_reject_q <= 1'b0;
      in_msk_q                    <= 32'h00000000;
      out_msk_q                   <= 32'h00000000;
    end else if (wr_fire) begin
      if (aw_q == ADDR_CFG) begin
        speed_select_q              <= wd_q[CFG_SPD_LO +: 2]; // RL3
        status_out_nonzero_reject_q <= wd_q[CFG_NZLS];
      end
      if (aw_q == ADDR_INMSK)
        in_msk_q <= wd_q & IN_MSK_BITS;   // RL22
      if (aw_q == ADDR_OUTMSK)
        out_msk_q <= wd_q & OUT_MSK_BITS; // RL22
    end
  end

  // ---------------------------------------------------------------
  // control register plain fields
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      remote_resume_request_q <= 1'b0;
      soft_link_drop_q        <= 1'b0;
      test_q                  <= 3'h0;
      init_q                  <= 1'b0;
    end else if (wr_ctl) begin
      remote_resume_request_q <= wd_q[CTL_RWK];
      soft_link_drop_q        <= wd_q[CTL_SD];
      test_q                  <= wd_q[CTL_TST +: 3];
      init_q                  <= wd_q[CTL_INIT]; // RL4
    end
  end

  // ---------------------------------------------------------------
  // global nak states; set and clear are write-one pulses
  // ---------------------------------------------------------------
  logic set_in;   // set IN pulse
  logic set_out;  // set OUT pulse
  assign set_in  = wr_ctl && wd_q[CTL_SGIN];
  assign set_out = wr_ctl && wd_q[CTL_SGON];

  // set wins over a clear written in the same word
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      global_in_nak_state_q  <= 1'b0;
      global_out_nak_state_q <= 1'b0;
    end else begin
      if (set_in)
        global_in_nak_state_q <= 1'b1;                       // RL9
      else if (wr_ctl && wd_q[CTL_CGIN])
        global_in_nak_state_q <= 1'b0;                       // RL8
      if (set_out)
        global_out_nak_state_q <= 1'b1;                      // RL6
      else if (wr_ctl && wd_q[CTL_CGON])
        global_out_nak_state_q <= 1'b0;                      // RL5
    end
  end

  // delay counters: flag rises a few cycles after a set from zero
  logic [2:0] in_dly_q;   // IN delay countdown
  logic [2:0] out_dly_q;  // OUT delay countdown
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_dly_q  <= 3'h0;
      out_dly_q <= 3'h0;
    end else begin
      if (set_in && !global_in_nak_state_q)
        in_dly_q <= 3'(NAK_DELAY);                            // RL9
      else if (in_dly_q != 3'h0)
        in_dly_q <= in_dly_q - 3'h1;
      if (set_out && !global_out_nak_state_q)
        out_dly_q <= 3'(NAK_DELAY);                           // RL6
      else if (out_dly_q != 3'h0)
        out_dly_q <= out_dly_q - 3'h1;
    end
  end

  // effective flags: the rising event wins over a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      global_in_nak_effective_flag  <= 1'b0;
      global_out_nak_effective_flag <= 1'b0;
    end else begin
      if (in_dly_q == 3'h1)
        global_in_nak_effective_flag <= 1'b1;
      else if (clear_in_nak_flag)
        global_in_nak_effective_flag <= 1'b0;
      if (out_dly_q == 3'h1)
        global_out_nak_effective_flag <= 1'b1;
      else if (clear_out_nak_flag)
        global_out_nak_effective_flag <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // handshake decisions for the link engine
  // ---------------------------------------------------------------
  always_comb begin
    resp.out_save = 1'b0;
    resp.out_hs   = HS_NAK;
    resp.in_hs    = HS_NAK;
    if (txn.out_valid) begin
      if (global_out_nak_state_q) begin
        resp.out_hs = HS_NAK;                                  // RL12
      end else if (txn.status_stage && txn.nonzero && status_out_nonzero_reject_q) begin
        resp.out_hs = HS_STALL;                                // RL2
      end else if (txn.ep_stall) begin
        resp.out_hs = HS_STALL;                                // RL1
      end else if (txn.ep_nak || !txn.fifo_ok) begin
        resp.out_hs = HS_NAK;
      end else begin
        resp.out_hs   = HS_ACK;
        resp.out_save = 1'b1;
      end
    end
    if (txn.in_valid) begin
      if (global_in_nak_state_q)
        resp.in_hs = HS_NAK;                                   // RL13
      else if (txn.ep_stall)
        resp.in_hs = HS_STALL;
      else if (txn.ep_nak || !txn.fifo_ok)
        resp.in_hs = HS_NAK;
      else
        resp.in_hs = HS_ACK;
    end
  end

  // ---------------------------------------------------------------
  // link control outputs
  // ---------------------------------------------------------------
  // pull-up held for one cycle of fallback so full speed is reached first
  logic drop_seen_q;  // fallback already applied
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      drop_seen_q         <= 1'b0;
      remote_resume_drive <= 1'b0;
    end else begin
      drop_seen_q         <= soft_link_drop_q;                 // RL14
      remote_resume_drive <= remote_resume_request_q && suspended; // RL15
    end
  end
  assign speed_select_hs     = (speed_select_q == SPD_HIGH) && !soft_link_drop_q; // RL14
  assign hs_fallback         = soft_link_drop_q;
  assign dp_pullup_en        = !(soft_link_drop_q && drop_seen_q);   // RL14
  assign test_pattern_select = test_q;                                // RL10
  assign test_mode_active    = (test_q != TST_OFF);                   // RL10
  assign init_done_notify    = init_q;

  // ---------------------------------------------------------------
  // status capture
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sof_frame_number_q <= 14'h0000;
      enum_speed_q       <= SPD_HIGH;
    end else begin
      if (sof_valid)
        sof_frame_number_q <= sof_frame;                       // RL16
      if (enum_done)
        enum_speed_q <= enum_speed;                            // RL17
    end
  end

  // per-endpoint masked interrupt bits
  genvar g;
  generate
    for (g = 0; g < N_EP; g++) begin : g_ep
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          in_int_q[g]  <= 1'b0;
          out_int_q[g] <= 1'b0;
        end else begin
          in_int_q[g]  <= |(in_ep_flags[g*32 +: 32] & in_msk_q);   // RL19
          out_int_q[g] <= |(out_ep_flags[g*32 +: 32] & out_msk_q); // RL20
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // read channel
  // ---------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OKAY;
      s_axi_rdata  <= 32'h00000000;
      case ({s_axi_araddr[11:2], 2'h0})
        ADDR_CFG: s_axi_rdata <= {29'h0, status_out_nonzero_reject_q, speed_select_q};
        // command bits read as zero
        ADDR_CTL: s_axi_rdata <= {20'h0, init_q, 4'h0, test_q, global_out_nak_state_q,
                                  global_in_nak_state_q, soft_link_drop_q,
                                  remote_resume_request_q};   // RL22
        ADDR_STAT: s_axi_rdata <= {10'h0, sof_frame_number_q, 5'h0, enum_speed_q,
                                   !suspended};               // RL18
        ADDR_INMSK:  s_axi_rdata <= in_msk_q;
        ADDR_OUTMSK: s_axi_rdata <= out_msk_q;
        ADDR_ALLEP: begin
          s_axi_rdata[N_EP-1:0]                    <= in_int_q;  // RL21
          s_axi_rdata[ALL_OUT_LO +: N_EP]          <= out_int_q; // RL21
        end
        default: s_axi_rresp <= RESP_SLVERR;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_out_nak_forced: assert property (@(posedge aclk) disable iff (!aresetn) // RL12
    txn.out_valid && global_out_nak_state_q |-> resp.out_hs == HS_NAK && !resp.out_save)
    else $error("out nak state not forcing nak");
  a_in_nak_forced: assert property (@(posedge aclk) disable iff (!aresetn) // RL13
    txn.in_valid && global_in_nak_state_q |-> resp.in_hs == HS_NAK)
    else $error("in nak state not forcing nak");
  a_status_stall: assert property (@(posedge aclk) disable iff (!aresetn) // RL2
    txn.out_valid && !global_out_nak_state_q && txn.status_stage && txn.nonzero &&
    status_out_nonzero_reject_q |-> resp.out_hs == HS_STALL && !resp.out_save)
    else $error("nonzero status packet not stalled");
  a_in_flag_delay: assert property (@(posedge aclk) disable iff (!aresetn) // RL9
    set_in && !global_in_nak_state_q |-> ##5 global_in_nak_effective_flag)
    else $error("in nak effective flag late");
  a_out_flag_delay: assert property (@(posedge aclk) disable iff (!aresetn) // RL6
    set_out && !global_out_nak_state_q |-> ##5 global_out_nak_effective_flag)
    else $error("out nak effective flag late");
  a_out_clear: assert property (@(posedge aclk) disable iff (!aresetn) // RL5
    wr_ctl && wd_q[CTL_CGON] && !wd_q[CTL_SGON] |=> !global_out_nak_state_q)
    else $error("out nak state not cleared");
  a_in_clear: assert property (@(posedge aclk) disable iff (!aresetn) // RL8
    wr_ctl && wd_q[CTL_CGIN] && !wd_q[CTL_SGIN] |=> !global_in_nak_state_q)
    else $error("in nak state not cleared");
  a_drop_order: assert property (@(posedge aclk) disable iff (!aresetn) // RL14
    $rose(soft_link_drop_q) |-> dp_pullup_en && !speed_select_hs ##1 !dp_pullup_en)
    else $error("pull-up dropped before fallback");
  a_sof_capture: assert property (@(posedge aclk) disable iff (!aresetn) // RL16
    sof_valid |=> sof_frame_number_q == $past(sof_frame))
    else $error("frame number not captured");
  a_resume_gate: assert property (@(posedge aclk) disable iff (!aresetn) // RL15
    !remote_resume_request_q |=> !remote_resume_drive)
    else $error("resume driven without request");

endmodule : udc_ctrl

/* udc_host_model.sv */
// bus-side partner model: issues start-of-frame tokens with a rolling frame number
`timescale 1ns/1ps
module udc_host_model (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        sof_req,
  output logic             sof_valid,
  output logic [13:0]      sof_frame
);
  logic [13:0] frame_q; // next frame to send, starts near wrap
  // one token per cycle of request; frame counts up and wraps at 14 bits
  always_ff @(posedge aclk) begin
    if (!aresetn) frame_q <= 14'h3FFE;
    else if (sof_req) frame_q <= frame_q + 14'h1;
  end
  assign sof_valid = sof_req;
  // outside a token the lines carry the inverted next frame number
  assign sof_frame = sof_req ? frame_q : ~frame_q;
endmodule : udc_host_model

/* testbench.sv */
// self-checking bench for the device control and status block
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin num_errors++; \
  $display("mismatch t=%0t got=%0h exp=%0h", $time, a, e); end end
module testbench;
  import udc_pkg::*;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, sof_valid, sof_req = 0, enum_done = 0, suspended = 0;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF; // whole words only
  logic [1:0]  s_axi_bresp, s_axi_rresp, enum_speed = 0;
  logic [13:0] sof_frame;
  logic [191:0] in_ep_flags = 0, out_ep_flags = 0;
  logic speed_select_hs, test_mode_active, hs_fallback, dp_pullup_en, remote_resume_drive;
  logic init_done_notify, global_in_nak_effective_flag, global_out_nak_effective_flag;
  logic clear_in_nak_flag = 0, clear_out_nak_flag = 0;
  logic [2:0]  test_pattern_select;
  udc_txn_t    txn = '0;
  udc_resp_t   resp;
  int num_errors = 0, n_checks = 0, cyc = 0;
  udc_ctrl #(.N_EP(6)) dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .txn, .resp, .sof_valid, .sof_frame, .enum_done, .enum_speed,
    .suspended, .in_ep_flags, .out_ep_flags, .speed_select_hs, .test_pattern_select,
    .test_mode_active, .hs_fallback, .dp_pullup_en, .remote_resume_drive, .init_done_notify,
    .global_in_nak_effective_flag, .global_out_nak_effective_flag, .clear_in_nak_flag,
    .clear_out_nak_flag);
  udc_host_model host (.aclk, .aresetn, .sof_req, .sof_valid, .sof_frame);
  initial forever #5 aclk = ~aclk;
  // hang guard: the whole run needs well under this many cycles
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin num_errors++; end_of_test(); end
  end
  task automatic end_of_test();
    if (num_errors == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_of_test
  // write one word; ready is looked at mid-cycle where it is settled
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic ta, tw;
    @(posedge aclk); s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1; s_axi_wvalid <= 1;
    do begin
      @(negedge aclk); ta = s_axi_awvalid && s_axi_awready; tw = s_axi_wvalid && s_axi_wready;
      @(posedge aclk); if (ta) s_axi_awvalid <= 0; if (tw) s_axi_wvalid <= 0;
    end while ((s_axi_awvalid && !ta) || (s_axi_wvalid && !tw));
    s_axi_bready <= 1;
    do @(negedge aclk); while (!s_axi_bvalid);
    `CHK(s_axi_bresp, RESP_OKAY)
    @(posedge aclk); s_axi_bready <= 0;
  endtask : wr
  // read one word and compare data and response
  task automatic rdc(input logic [11:0] a, input logic [31:0] e, input logic [1:0] r);
    @(posedge aclk); s_axi_araddr <= a; s_axi_arvalid <= 1;
    do @(negedge aclk); while (!s_axi_arready);
    @(posedge aclk); s_axi_arvalid <= 0; s_axi_rready <= 1;
    do @(negedge aclk); while (!s_axi_rvalid);
    `CHK(s_axi_rdata, e) `CHK(s_axi_rresp, r)
    @(posedge aclk); s_axi_rready <= 0;
  endtask : rdc
  task automatic tx(input udc_txn_t t);
    @(posedge aclk); txn <= t; @(negedge aclk);
  endtask : tx
  // bounded wait for a level output
  task automatic wt(ref logic s);
    for (int i = 0; i < 30 && s !== 1'b1; i++) @(negedge aclk);
  endtask : wt
  // set/clear of one global nak; o selects the OUT direction
  task automatic t_nak(input bit o);
    wr(ADDR_CTL, 32'h1 << (o ? 9 : 7));
    rdc(ADDR_CTL, 32'h1 << (o ? 3 : 2), RESP_OKAY);
    if (o) wt(global_out_nak_effective_flag); else wt(global_in_nak_effective_flag);
    `CHK(o ? global_out_nak_effective_flag : global_in_nak_effective_flag, 1'b1)
    tx(o ? 7'b1000001 : 7'b0001001);
    `CHK(o ? resp.out_hs : resp.in_hs, HS_NAK)
    if (o) `CHK(resp.out_save, 1'b0)
    @(posedge aclk); clear_out_nak_flag <= o; clear_in_nak_flag <= !o;
    @(posedge aclk); clear_out_nak_flag <= 0; clear_in_nak_flag <= 0;
    wr(ADDR_CTL, 32'h1 << (o ? 10 : 8));
    rdc(ADDR_CTL, 32'h0, RESP_OKAY);
    `CHK(o ? global_out_nak_effective_flag : global_in_nak_effective_flag, 1'b0)
    `CHK(o ? resp.out_hs : resp.in_hs, HS_ACK)
  endtask : t_nak
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    rdc(ADDR_CTL, 32'h0, RESP_OKAY);
    rdc(ADDR_STAT, 32'h1, RESP_OKAY);
    rdc(12'hFF0, 32'h0, RESP_SLVERR);
    `CHK(speed_select_hs, 1'b1)
    wr(ADDR_INMSK, 32'hFFFFFFFF); rdc(ADDR_INMSK, 32'h0000205B, RESP_OKAY);
    wr(ADDR_OUTMSK, 32'hFFFFFFFF); rdc(ADDR_OUTMSK, 32'h0000405A, RESP_OKAY);
    @(posedge aclk); in_ep_flags <= 192'h1 << 64; out_ep_flags <= 192'h1 << 174;
    repeat (3) @(posedge aclk);
    rdc(ADDR_ALLEP, 32'h00200004, RESP_OKAY);
    t_nak(1); t_nak(0);
    // status-stage packet with data: rejected, then handled normally
    wr(ADDR_CFG, 32'h4 | 32'h1);
    `CHK(speed_select_hs, 1'b0)
    tx(7'b1110001); `CHK(resp.out_hs, HS_STALL) `CHK(resp.out_save, 1'b0)
    wr(ADDR_CFG, 32'h0);
    `CHK(resp.out_hs, HS_ACK) `CHK(resp.out_save, 1'b1)
    tx(7'b1110101); `CHK(resp.out_hs, HS_NAK)
    for (int i = 0; i < 6; i++) begin
      // the high-speed current feature bit sits outside this block
      wr(ADDR_CTL, i << 4);
      `CHK(test_pattern_select, 3'(i)) `CHK(test_mode_active, i != 0)
    end
    @(posedge aclk); sof_req <= 1; enum_speed <= SPD_FULL; enum_done <= 1; suspended <= 1;
    @(posedge aclk); enum_done <= 0;
    @(posedge aclk); sof_req <= 0; enum_speed <= 2'h3;
    rdc(ADDR_STAT, 32'h003FFF02, RESP_OKAY);
    wr(ADDR_CTL, 32'h1); wt(remote_resume_drive); `CHK(remote_resume_drive, 1'b1)
    wr(ADDR_CTL, 32'h2); `CHK(hs_fallback, 1'b1)
    repeat (2) @(negedge aclk); `CHK(dp_pullup_en, 1'b0) `CHK(speed_select_hs, 1'b0)
    wr(ADDR_CTL, 32'h800); `CHK(init_done_notify, 1'b1)
    end_of_test();
  end
endmodule : testbench
